// ==== pkg/output_regs_pkg.sv ====
// package: register map, reset values, command codes, timing counts
// assumes a 10 MHz system clock
package output_regs_pkg;
  // ----------------------------------------
  // register map (holding register offsets)
  // ----------------------------------------
  localparam logic [15:0] slave_address_off     = 16'h9c41;
  localparam logic [15:0] uart_setup_off        = 16'h9c42;
  localparam logic [15:0] delays_off            = 16'h9c43;
  localparam logic [15:0] firmware_version_off  = 16'h9c61;
  localparam logic [15:0] timeout_interval_off  = 16'h9ca0;
  localparam logic [15:0] power_on_pattern_off  = 16'h9ca1;
  localparam logic [15:0] command_off           = 16'h9d31;
  // ----------------------------------------
  // reset values and limits
  // ----------------------------------------
  localparam logic [15:0] slave_address_rst     = 16'h0001;
  localparam logic [15:0] slave_address_max     = 16'h00df;
  localparam logic [15:0] slave_address_min     = 16'h0001;
  localparam logic [15:0] uart_setup_rst        = 16'h0035;
  localparam logic [15:0] delays_rst            = 16'h0003;
  localparam logic [15:0] timeout_interval_rst  = 16'hffff;
  localparam logic [15:0] timeout_disabled      = 16'hffff;
  localparam logic [15:0] power_on_pattern_rst  = 16'h0000;
  localparam logic [7:0]  reply_delay_max_ms    = 8'h3f;
  localparam logic [7:0]  query_delay_max_ms    = 8'h30;
  localparam int          reply_lsb             = 0;
  localparam int          query_lsb             = 8;
  localparam int          channels              = 15;
  // ----------------------------------------
  // command codes
  // ----------------------------------------
  localparam logic [15:0] cmd_nop               = 16'h0000;
  localparam logic [15:0] cmd_remote_reset      = 16'h0001;
  localparam logic [15:0] cmd_write_enable      = 16'h0002;
  localparam logic [15:0] cmd_sync_sample       = 16'h0003;
  localparam logic [15:0] cmd_host_com_init     = 16'h0005;
  // ----------------------------------------
  // coil map
  // ----------------------------------------
  localparam logic [15:0] coil_out_last         = 16'h000e;
  localparam logic [15:0] coil_sync_first       = 16'h0100;
  localparam logic [15:0] coil_sync_last        = 16'h010e;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int          clk_hz                = 10_000_000;
  localparam int          ms_ns                 = 1_000_000;
  localparam int          clk_ns                = 1_000_000_000 / clk_hz;
  localparam int          cycles_per_ms         = ms_ns / clk_ns;
  localparam int          ms_per_s              = 1000;
endpackage : output_regs_pkg

// ==== hdl/ms_tick.sv ====
// millisecond tick divider
// assumes a single free-running clock, period from the package
`timescale 1ns/100ps
module ms_tick #(
  parameter int cycles = output_regs_pkg::cycles_per_ms
) (
  input  wire logic clk,
  input  wire logic reset_n,
  output logic      tick
);
  typedef struct packed {
    logic [15:0] count;
    logic        tick;
  } tick_state_t;

  tick_state_t state;
  tick_state_t next_state;

  always_comb begin
    next_state = state;
    next_state.tick = 1'b0;
    if (state.count == 16'(cycles - 1)) begin
      next_state.count = 16'h0000;
      next_state.tick = 1'b1;
    end else begin
      next_state.count = state.count + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign tick = state.tick;
endmodule : ms_tick

// ==== hdl/modbus_output_module_regs.sv ====
// holding register bank, coil map and comm watchdog for a 15 channel
// discrete output slave
// assumes a frame decoder in front: one-cycle strobes, same clock
`timescale 1ns/100ps
module modbus_output_module_regs #(
  parameter logic [15:0] firmware_code      = 16'h0100, // arbitrary value
  parameter int          watchdog_ms_cycles = output_regs_pkg::cycles_per_ms,
  parameter int          ms_per_second      = output_regs_pkg::ms_per_s
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic [15:0]      reg_rdata,
  output logic             reg_ack,
  output logic             reg_err,
  input  wire logic        coil_wr,
  input  wire logic        coil_rd,
  input  wire logic [15:0] coil_addr,
  input  wire logic        coil_wdata,
  output logic             coil_rdata,
  output logic             coil_ack,
  output logic             coil_err,
  input  wire logic        request_valid,
  input  wire logic        query_silence,
  output logic             query_done,
  input  wire logic        reply_ready,
  output logic             reply_go,
  output logic [14:0]      outputs,
  output logic             remote_reset,
  output logic             host_com_init,
  output logic [15:0]      slave_address,
  output logic [15:0]      uart_setup
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [1:0] {
    idle    = 2'b00,
    q_wait  = 2'b01,
    r_wait  = 2'b11
  } phase_t;

  typedef struct packed {
    logic [15:0] slave_address;
    logic [15:0] uart_setup;
    logic [15:0] delays;
    logic [15:0] interval;
    logic [15:0] pattern;
    logic [14:0] outputs;
    logic [14:0] sampled;
    logic        wr_enabled;
    logic [15:0] wd_seconds;
    logic [15:0] wd_ms;
    logic        wd_fired;
    phase_t      phase;
    logic [7:0]  delay_ms;
    logic [15:0] reg_rdata;
    logic        reg_ack;
    logic        reg_err;
    logic        coil_rdata;
    logic        coil_ack;
    logic        coil_err;
    logic        query_done;
    logic        reply_go;
    logic        remote_reset;
    logic        host_com_init;
  } regs_state_t;

  regs_state_t state;
  regs_state_t next_state;
  logic        tick;

  ms_tick #(
    .cycles (watchdog_ms_cycles)
  ) u_tick (
    .clk     (clk),
    .reset_n (reset_n),
    .tick    (tick)
  );

  function automatic logic [7:0] clamp8(input logic [7:0] v,
                                        input logic [7:0] lim);
    clamp8 = (v > lim) ? lim : v;
  endfunction : clamp8

  function automatic logic is_protected(input logic [15:0] a);
    is_protected = (a == output_regs_pkg::slave_address_off) ||
                   (a == output_regs_pkg::uart_setup_off) ||
                   (a == output_regs_pkg::delays_off) ||
                   (a == output_regs_pkg::timeout_interval_off) ||
                   (a == output_regs_pkg::power_on_pattern_off);
  endfunction : is_protected

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_state.reg_ack = 1'b0;
    next_state.reg_err = 1'b0;
    next_state.coil_ack = 1'b0;
    next_state.coil_err = 1'b0;
    next_state.query_done = 1'b0;
    next_state.reply_go = 1'b0;
    next_state.remote_reset = 1'b0;
    next_state.host_com_init = 1'b0;

    // register reads; command register reads as zero with reg_err, like unmapped addresses
    if (reg_rd) begin
      next_state.reg_ack = 1'b1;
      case (reg_addr)
        output_regs_pkg::slave_address_off:
          next_state.reg_rdata = state.slave_address;
        output_regs_pkg::uart_setup_off:
          next_state.reg_rdata = state.uart_setup;
        output_regs_pkg::delays_off:
          next_state.reg_rdata = state.delays;
        output_regs_pkg::firmware_version_off:
          next_state.reg_rdata = firmware_code;
        output_regs_pkg::timeout_interval_off:
          next_state.reg_rdata = state.interval;
        output_regs_pkg::power_on_pattern_off:
          next_state.reg_rdata = state.pattern;
        default: begin
          next_state.reg_rdata = 16'h0000;
          next_state.reg_err = 1'b1;
        end
      endcase
    end else if (reg_wr) begin
      next_state.reg_ack = 1'b1;
      if (reg_addr == output_regs_pkg::command_off) begin
        case (reg_wdata)
          output_regs_pkg::cmd_nop: ;
          output_regs_pkg::cmd_remote_reset:
            next_state.remote_reset = state.wr_enabled;
          output_regs_pkg::cmd_write_enable:
            next_state.wr_enabled = 1'b1;
          output_regs_pkg::cmd_sync_sample:
            next_state.sampled = state.outputs;
          output_regs_pkg::cmd_host_com_init:
            next_state.host_com_init = 1'b1;
          default:
            next_state.reg_err = 1'b1;
        endcase
      end else if (!is_protected(reg_addr)) begin
        // firmware version and unmapped addresses refuse writes
        next_state.reg_err = 1'b1;
      end else if (!state.wr_enabled) begin
        next_state.reg_err = 1'b1;
      end else begin
        case (reg_addr)
          output_regs_pkg::slave_address_off: begin
            if (reg_wdata >= output_regs_pkg::slave_address_min &&
                reg_wdata <= output_regs_pkg::slave_address_max) begin
              next_state.slave_address = reg_wdata;
            end else begin
              next_state.reg_err = 1'b1;
            end
          end
          output_regs_pkg::uart_setup_off:
            next_state.uart_setup = reg_wdata;
          output_regs_pkg::delays_off: begin
            next_state.delays = {
              clamp8(reg_wdata[15:8],
                     output_regs_pkg::query_delay_max_ms),
              clamp8(reg_wdata[7:0],
                     output_regs_pkg::reply_delay_max_ms)};
          end
          output_regs_pkg::timeout_interval_off:
            next_state.interval = reg_wdata;
          default:
            next_state.pattern = reg_wdata;
        endcase
      end
    end

    // coil access
    if (coil_rd || coil_wr) begin
      next_state.coil_ack = 1'b1;
      next_state.coil_rdata = 1'b0;
      if (coil_addr <= output_regs_pkg::coil_out_last) begin
        if (coil_wr) begin
          next_state.outputs[coil_addr[3:0]] = coil_wdata;
        end
        next_state.coil_rdata = state.outputs[coil_addr[3:0]];
      end else if (coil_rd &&
                   coil_addr >= output_regs_pkg::coil_sync_first &&
                   coil_addr <= output_regs_pkg::coil_sync_last) begin
        next_state.coil_rdata = state.sampled[coil_addr[3:0]];
      end else begin
        next_state.coil_err = 1'b1;
      end
    end

    // ----------------------------------------
    // comm watchdog
    // ----------------------------------------
    // counts whole seconds from ms ticks; disabled value never fires
    if (request_valid) begin
      next_state.wd_seconds = 16'h0000;
      next_state.wd_ms = 16'h0000;
      next_state.wd_fired = 1'b0;
    end else if (state.interval != output_regs_pkg::timeout_disabled &&
                 !state.wd_fired && tick) begin
      if (state.wd_ms == 16'(ms_per_second - 1)) begin
        next_state.wd_ms = 16'h0000;
        next_state.wd_seconds = state.wd_seconds + 16'h0001;
      end else begin
        next_state.wd_ms = state.wd_ms + 16'h0001;
      end
    end
    if (state.interval != output_regs_pkg::timeout_disabled &&
        !state.wd_fired && !request_valid &&
        state.wd_seconds >= state.interval) begin
      next_state.wd_fired = 1'b1;
      next_state.outputs = state.pattern[14:0];
    end

    // ----------------------------------------
    // end of query and reply delays
    // ----------------------------------------
    case (state.phase)
      idle: begin
        if (query_silence) begin
          next_state.phase = q_wait;
          next_state.delay_ms = state.delays[15:8];
        end
      end
      q_wait: begin
        if (state.delay_ms == 8'h00) begin
          next_state.query_done = 1'b1;
          next_state.phase = r_wait;
          next_state.delay_ms = state.delays[7:0];
        end else if (tick) begin
          next_state.delay_ms = state.delay_ms - 8'h01;
        end
      end
      r_wait: begin
        if (state.delay_ms == 8'h00) begin
          if (reply_ready) begin
            next_state.reply_go = 1'b1;
            next_state.phase = idle;
          end
        end else if (tick) begin
          next_state.delay_ms = state.delay_ms - 8'h01;
        end
      end
      default: next_state.phase = idle;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state               <= '0;
      state.slave_address <= output_regs_pkg::slave_address_rst;
      state.uart_setup    <= output_regs_pkg::uart_setup_rst;
      state.delays        <= output_regs_pkg::delays_rst;
      state.interval      <= output_regs_pkg::timeout_interval_rst;
      state.pattern       <= output_regs_pkg::power_on_pattern_rst;
      state.outputs       <= output_regs_pkg::power_on_pattern_rst[14:0];
      state.phase         <= idle;
    end else begin
      state <= next_state;
    end
  end

  assign reg_rdata     = state.reg_rdata;
  assign reg_ack       = state.reg_ack;
  assign reg_err       = state.reg_err;
  assign coil_rdata    = state.coil_rdata;
  assign coil_ack      = state.coil_ack;
  assign coil_err      = state.coil_err;
  assign query_done    = state.query_done;
  assign reply_go      = state.reply_go;
  assign outputs       = state.outputs;
  assign remote_reset  = state.remote_reset;
  assign host_com_init = state.host_com_init;
  assign slave_address = state.slave_address;
  assign uart_setup    = state.uart_setup;
endmodule : modbus_output_module_regs

// ==== verification/modbus_output_module_regs_checker.sv ====
// checker: port relations of the holding register bank
// assumes a bind onto the bank, one clock domain
`timescale 1ns/100ps
module modbus_output_module_regs_checker #(
  parameter logic [15:0] firmware_code = 16'h0100 // arbitrary value
) (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic        reg_err,
  input wire logic        coil_rd,
  input wire logic [15:0] coil_addr,
  input wire logic        coil_rdata,
  input wire logic        coil_ack,
  input wire logic [14:0] outputs,
  input wire logic        remote_reset,
  input wire logic        host_com_init,
  input wire logic [15:0] slave_address
);
  logic fw_hit, wr_sa, rd_dly, cmd_hit, cmd_rst, cmd_init, coil_lo, coil_bit;
  assign fw_hit   = reg_addr == output_regs_pkg::firmware_version_off;
  assign wr_sa    = reg_wr && !reg_rd
                    && reg_addr == output_regs_pkg::slave_address_off;
  assign rd_dly   = reg_rd && reg_addr == output_regs_pkg::delays_off;
  assign cmd_hit  = reg_wr && !reg_rd
                    && reg_addr == output_regs_pkg::command_off;
  assign cmd_rst  = cmd_hit && reg_wdata == 16'h0001;
  assign cmd_init = cmd_hit && reg_wdata == 16'h0005;
  assign coil_lo  = coil_rd && coil_addr <= 16'h000e;
  assign coil_bit = outputs[coil_addr[3:0]];
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  property p_addr_range;
    slave_address >= 16'h0001 && slave_address <= 16'h00df;
  endproperty
  a_addr_range: assert property (p_addr_range)
    else $error("slave address out of range");
  property p_addr_refuse;
    wr_sa && (reg_wdata == 16'h0000 || reg_wdata > 16'h00df)
      |=> reg_err && $stable(slave_address);
  endproperty
  a_addr_refuse: assert property (p_addr_refuse)
    else $error("bad slave address taken");
  property p_fw_read;
    reg_rd && fw_hit |=> reg_rdata == firmware_code && !reg_err;
  endproperty
  a_fw_read: assert property (p_fw_read)
    else $error("version read wrong");
  property p_fw_write;
    reg_wr && !reg_rd && fw_hit |=> reg_err;
  endproperty
  a_fw_write: assert property (p_fw_write)
    else $error("version write not refused");
  property p_delay;
    rd_dly |=> reg_rdata[7:0] <= 8'h3f && reg_rdata[15:8] <= 8'h30;
  endproperty
  a_delay: assert property (p_delay)
    else $error("delay byte above limit");
  property p_coil_map;
    coil_lo |=> coil_ack && coil_rdata == $past(coil_bit);
  endproperty
  a_coil_map: assert property (p_coil_map)
    else $error("coil read wrong channel");
  property p_reset_cause;
    remote_reset |-> $past(cmd_rst);
  endproperty
  a_reset_cause: assert property (p_reset_cause)
    else $error("remote reset without command");
  property p_init_cause;
    host_com_init |-> $past(cmd_init);
  endproperty
  a_init_cause: assert property (p_init_cause)
    else $error("com init without command");
endmodule : modbus_output_module_regs_checker

bind modbus_output_module_regs modbus_output_module_regs_checker #(
  .firmware_code(firmware_code)
) i_modbus_output_module_regs_checker (
  .clk           (clk),
  .reset_n       (reset_n),
  .reg_wr        (reg_wr),
  .reg_rd        (reg_rd),
  .reg_addr      (reg_addr),
  .reg_wdata     (reg_wdata),
  .reg_rdata     (reg_rdata),
  .reg_err       (reg_err),
  .coil_rd       (coil_rd),
  .coil_addr     (coil_addr),
  .coil_rdata    (coil_rdata),
  .coil_ack      (coil_ack),
  .outputs       (outputs),
  .remote_reset  (remote_reset),
  .host_com_init (host_com_init),
  .slave_address (slave_address)
);

// ==== verification/modbus_host_model.sv ====
// host model: master side of the register and coil request ports
// assumes the bench calls its tasks; drives on falling edges only
`timescale 1ns/100ps
module modbus_host_model (
  input  wire logic        clk,
  input  wire logic [15:0] reg_rdata,
  input  wire logic        reg_ack,
  input  wire logic        reg_err,
  input  wire logic        coil_rdata,
  input  wire logic        coil_ack,
  input  wire logic        coil_err,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic [15:0]      reg_addr,
  output logic [15:0]      reg_wdata,
  output logic             coil_wr,
  output logic             coil_rd,
  output logic [15:0]      coil_addr,
  output logic             coil_wdata
);
  initial begin
    {reg_wr, reg_rd, coil_wr, coil_rd, coil_wdata} = '0;
    {reg_addr, reg_wdata, coil_addr} = '0;
  end
  // one strobe cycle, answer taken at the next falling edge
  task automatic reg_cyc(input logic w, input logic [15:0] a, d,
                         output logic [15:0] q, output logic k, r);
    @(negedge clk);
    reg_wr = w;
    reg_rd = !w;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    q = reg_rdata;
    k = reg_ack;
    r = reg_err;
    {reg_wr, reg_rd} = 2'b00;
    // released lines carry junk, not the last request
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : reg_cyc
  task automatic coil_cyc(input logic w, input logic [15:0] a,
                          input logic d, output logic q, k, r);
    @(negedge clk);
    coil_wr = w;
    coil_rd = !w;
    coil_addr = a;
    coil_wdata = d;
    @(negedge clk);
    q = coil_rdata;
    k = coil_ack;
    r = coil_err;
    {coil_wr, coil_rd} = 2'b00;
    coil_addr = ~a;
    coil_wdata = ~d;
  endtask : coil_cyc
endmodule : modbus_host_model

// ==== verification/modbus_output_module_regs_bench.sv ====
// bench: register bank driven through the host model, answers checked
// assumes shortened ms and second counts so the watchdog fits the run
`timescale 1ns/100ps
module modbus_output_module_regs_bench;
  localparam logic [15:0] fw = 16'h0a5c; // arbitrary value
  localparam logic [15:0] sa = output_regs_pkg::slave_address_off;
  localparam logic [15:0] dl = output_regs_pkg::delays_off;
  localparam logic [15:0] vr = output_regs_pkg::firmware_version_off;
  localparam logic [15:0] wd = output_regs_pkg::timeout_interval_off;
  localparam logic [15:0] cm = output_regs_pkg::command_off;
  logic        clk, reset_n, reg_wr, reg_rd, reg_ack, reg_err, coil_wr;
  logic        coil_rd, coil_wdata, coil_rdata, coil_ack, coil_err;
  logic        request_valid, query_silence, query_done, reply_ready;
  logic        reply_go, remote_reset, host_com_init;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, coil_addr;
  logic [15:0] slave_address, uart_setup, m_pat;
  logic [14:0] outputs, m_out, m_smp;
  int          err_total, samples_checked, cycles, n, n_rst, n_init;
  modbus_output_module_regs #(
    .firmware_code     (fw),
    .watchdog_ms_cycles(10),
    .ms_per_second     (4)
  ) i_modbus_output_module_regs (
    .clk           (clk),
    .reset_n       (reset_n),
    .reg_wr        (reg_wr),
    .reg_rd        (reg_rd),
    .reg_addr      (reg_addr),
    .reg_wdata     (reg_wdata),
    .reg_rdata     (reg_rdata),
    .reg_ack       (reg_ack),
    .reg_err       (reg_err),
    .coil_wr       (coil_wr),
    .coil_rd       (coil_rd),
    .coil_addr     (coil_addr),
    .coil_wdata    (coil_wdata),
    .coil_rdata    (coil_rdata),
    .coil_ack      (coil_ack),
    .coil_err      (coil_err),
    .request_valid (request_valid),
    .query_silence (query_silence),
    .query_done    (query_done),
    .reply_ready   (reply_ready),
    .reply_go      (reply_go),
    .outputs       (outputs),
    .remote_reset  (remote_reset),
    .host_com_init (host_com_init),
    .slave_address (slave_address),
    .uart_setup    (uart_setup)
  );
  modbus_host_model i_modbus_host_model (
    .clk        (clk),
    .reg_rdata  (reg_rdata),
    .reg_ack    (reg_ack),
    .reg_err    (reg_err),
    .coil_rdata (coil_rdata),
    .coil_ack   (coil_ack),
    .coil_err   (coil_err),
    .reg_wr     (reg_wr),
    .reg_rd     (reg_rd),
    .reg_addr   (reg_addr),
    .reg_wdata  (reg_wdata),
    .coil_wr    (coil_wr),
    .coil_rd    (coil_rd),
    .coil_addr  (coil_addr),
    .coil_wdata (coil_wdata)
  );
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (remote_reset === 1'b1) n_rst++;
    if (host_com_init === 1'b1) n_init++;
    if (cycles == 5000) begin
      err_total++;
      finish_test;
    end
  end
  task automatic chkv(input logic [15:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chkv
  task automatic chkf(input logic got, exp);
    chkv({15'h0000, got}, {15'h0000, exp});
  endtask : chkf
  task automatic rw(input logic w, input logic [15:0] a, d,
                    input logic e);
    logic [15:0] q;
    logic        k, r;
    i_modbus_host_model.reg_cyc(w, a, d, q, k, r);
    chkf(k, 1'b1);
    if (e !== 1'bx) chkf(r, e);
    if (!w && !e) chkv(q, d);
  endtask : rw
  task automatic coil(input logic w, input logic [15:0] a,
                      input logic d, e);
    logic q, k, r;
    i_modbus_host_model.coil_cyc(w, a, d, q, k, r);
    chkf(k, 1'b1);
    chkf(r, e);
    if (!w && !e) chkf(q, d);
  endtask : coil
  task automatic pulse_req;
    @(negedge clk);
    request_valid = 1'b1;
    @(negedge clk);
    request_valid = 1'b0;
  endtask : pulse_req
  task automatic wait_on(input int sel, output int k);
    k = 0;
    while (k < 300 && !(sel == 0 ? query_done === 1'b1 :
           sel == 1 ? reply_go === 1'b1 : outputs === m_pat[14:0])) begin
      @(negedge clk);
      k++;
    end
  endtask : wait_on
  task automatic finish_test;
    if (err_total == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test
  initial begin
    void'($urandom(44087));
    {reset_n, request_valid, query_silence, reply_ready} = '0;
    repeat (12) @(posedge clk);
    @(negedge clk);
    reset_n = 1'b1;
    rw(1'b0, sa, 16'h0001, 1'b0);
    rw(1'b0, output_regs_pkg::uart_setup_off, 16'h0035, 1'b0);
    rw(1'b0, dl, 16'h0003, 1'b0);
    rw(1'b0, wd, 16'hffff, 1'b0);
    rw(1'b0, output_regs_pkg::power_on_pattern_off, 16'h0000, 1'b0);
    chkv(uart_setup, 16'h0035);
    rw(1'b0, vr, fw, 1'b0);
    rw(1'b0, cm, 16'h0000, 1'b1);
    chkv(16'(outputs), 16'h0000);
    rw(1'b1, sa, 16'h0005, 1'b1);
    rw(1'b1, cm, 16'h0001, 1'b0);
    rw(1'b1, output_regs_pkg::uart_setup_off, 16'h1234, 1'b1);
    // host enables writes; protected register writes before this were refused
    rw(1'b1, cm, 16'h0002, 1'b0);
    rw(1'b1, output_regs_pkg::uart_setup_off, 16'h1234, 1'b0);
    chkv(uart_setup, 16'h1234);
    rw(1'b1, sa, 16'h0000, 1'b1);
    rw(1'b1, sa, 16'h00e0, 1'b1);
    rw(1'b1, sa, 16'h00df, 1'b0);
    chkv(slave_address, 16'h00df);
    rw(1'b1, dl, 16'hffff, 1'b0);
    rw(1'b0, dl, 16'h303f, 1'b0);
    rw(1'b1, vr, 16'h5a5a, 1'b1);
    rw(1'b0, vr, fw, 1'b0);
    rw(1'b1, cm, 16'h0004, 1'b1);
    rw(1'b1, cm, 16'h0000, 1'b0);
    for (int c = 0; c < 15; c++) begin
      m_out[c] = 1'($urandom);
      coil(1'b1, 16'(c), m_out[c], 1'b0);
    end
    chkv(16'(outputs), 16'(m_out));
    coil(1'b1, 16'h0100, 1'b1, 1'b1);
    rw(1'b1, cm, 16'h0003, 1'b0);
    m_smp = m_out;
    m_out = ~m_out;
    for (int c = 0; c < 15; c++) begin
      coil(1'b1, 16'(c), m_out[c], 1'b0);
      coil(1'b0, 16'(c), m_out[c], 1'b0);
      coil(1'b0, 16'h0100 + 16'(c), m_smp[c], 1'b0);
    end
    coil(1'b0, 16'h010f, 1'b0, 1'b1);
    m_pat = {1'($urandom), ~m_out};
    rw(1'b1, output_regs_pkg::power_on_pattern_off, m_pat, 1'b0);
    pulse_req;
    rw(1'b1, wd, 16'h0001, 1'b0);
    repeat (6) begin
      repeat (20) @(negedge clk);
      pulse_req;
    end
    chkv(16'(outputs), 16'(m_out));
    wait_on(2, n);
    chkf(n >= 25 && n <= 50, 1'b1);
    m_out = m_pat[14:0];
    pulse_req;
    rw(1'b1, wd, 16'hffff, 1'b0);
    m_out[0] = ~m_out[0];
    coil(1'b1, 16'h0000, m_out[0], 1'b0);
    repeat (200) @(negedge clk);
    chkv(16'(outputs), 16'(m_out));
    rw(1'b1, dl, 16'h0102, 1'b0);
    reply_ready = 1'b1;
    @(negedge clk);
    query_silence = 1'b1;
    @(negedge clk);
    query_silence = 1'b0;
    wait_on(0, n);
    chkf(n <= 14, 1'b1);
    wait_on(1, n);
    chkf(n >= 8 && n <= 25, 1'b1);
    rw(1'b1, cm, 16'h0005, 1'b0);
    rw(1'b1, cm, 16'h0001, 1'b0);
    repeat (2) @(negedge clk);
    chkv(16'(n_init), 16'h0001);
    chkv(16'(n_rst), 16'h0001);
    finish_test;
  end
endmodule : modbus_output_module_regs_bench
